// *** hw/pad_ctrl_consts.svh ***
// Constants for the pad function and low-power state controller.
// Assumes inclusion by bare name from the pad cell, the controller and the bench.
`ifndef PAD_CTRL_CONSTS_SVH
`define PAD_CTRL_CONSTS_SVH

// ****************************************************************
// Register byte addresses on APB
// ****************************************************************
`define ADDR_PIN63_FUNC     32'h4402e0c0
`define ADDR_PIN64_FUNC     32'h4402e0c4
`define ADDR_PAD_CTRL       32'h4402e0c8
`define ADDR_PAD_STATUS     32'h4402e0cc

// ****************************************************************
// Field layout
// ****************************************************************
`define MODE_MSB            3
`define CTRL_P63_PU         0
`define CTRL_P63_PD         1
`define CTRL_P63_USED       2
`define CTRL_P64_PU         3
`define CTRL_P64_PD         4
`define CTRL_P64_USED       5
`define CTRL_FLASH_PD       6
`define CTRL_CONV_SW        8
`define CTRL_DIG_EN         9
`define STAT_DEEP_SLEEP     0
`define STAT_HIBERNATE      1
`define STAT_DIG_EN         2
`define STAT_SW_UNSAFE      3
`define STAT_P63_LEVEL      4
`define STAT_P64_LEVEL      5

// ****************************************************************
// Reset values and mode codes
// ****************************************************************
`define MODE_RESET          4'h0
`define MODE_GPIO           4'h0
`define MODE_NONE           4'hf
`define P63_CARD_IRQ        4'h6
`define P63_FRAME_SYNC      4'h7
`define P63_CAPTURE6        4'hc
`define P64_PULSE5          4'h3
`define P64_CARD_DATA0      4'h6
`define P64_AUDIO_DATA0     4'h7
`define P64_CAPTURE0        4'hc
`define P63_SLOTS           5'h0f
`define P64_SLOTS           5'h1f
`define ZERO_WORD           32'h00000000

`endif

// *** hw/pad_ctrl_pkg.sv ***
// Types shared by the pad controller and its pad cells.
// Assumes the constants header sits beside it.
package pad_ctrl_pkg;
    // Power state seen by the pads
    typedef enum logic [1:0] {
        pwr_active      = 2'b00,
        pwr_deep_sleep  = 2'b01,
        pwr_hibernate   = 2'b10
    } power_state_type;
endpackage

// *** hw/pad_mux_cell.sv ***
// One multiplexed digital pad: function select, pulls, low-power states.
// Assumes the pad input arrives asynchronously from the package pin.
`timescale 1ns/10ps
`include "pad_ctrl_consts.svh"

module pad_mux_cell #(
    parameter logic [3:0] MODE_S1 = `MODE_NONE,
    parameter logic [3:0] MODE_S2 = `MODE_NONE,
    parameter logic [3:0] MODE_S3 = `MODE_NONE,
    parameter logic [3:0] MODE_S4 = `MODE_NONE,
    parameter logic [4:0] SLOT_EN = `P64_SLOTS
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic [3:0]                    mode,
    input  wire pad_ctrl_pkg::power_state_type power,
    input  wire logic                          dig_en,
    input  wire logic                          used,
    input  wire logic                          pull_up_sw,
    input  wire logic                          pull_dn_sw,
    input  wire logic [4:0]                    fn_out,
    input  wire logic [4:0]                    fn_oe,
    output logic      [4:0]                    fn_in,
    input  wire logic                          pad_in,
    output logic                               pad_out,
    output logic                               pad_oe,
    output logic                               pad_pull_up,
    output logic                               pad_pull_down,
    output logic                               pad_level
);
    logic [3:0] codes [5];
    logic       hit;
    logic [2:0] slot;
    logic       sync_a;
    logic       next_out;
    logic       next_oe;
    logic       next_pu;
    logic       next_pd;

    assign codes[0] = `MODE_GPIO;
    assign codes[1] = MODE_S1;
    assign codes[2] = MODE_S2;
    assign codes[3] = MODE_S3;
    assign codes[4] = MODE_S4;

    // Map the mode value to one slot; unlisted values hit nothing
    always_comb begin
        hit  = 1'b0;
        slot = 3'h0;
        for (int i = 0; i < 5; i++) begin
            if (SLOT_EN[i] && mode == codes[i] && !hit) begin
                hit  = 1'b1;
                slot = 3'(i);
            end
        end
    end

    // Pad drive and pulls by power state
    always_comb begin
        next_out = fn_out[slot];
        next_oe  = 1'b0;
        next_pu  = 1'b0;
        next_pd  = 1'b0;
        case (power)
            pad_ctrl_pkg::pwr_hibernate: begin
                next_out = 1'b0;
            end
            pad_ctrl_pkg::pwr_deep_sleep: begin
                if (!used) begin
                    next_pd = 1'b1;
                end else begin
                    next_oe = hit && dig_en && fn_oe[slot];
                    next_pu = pull_up_sw;
                    next_pd = pull_dn_sw;
                end
            end
            default: begin
                next_oe = hit && dig_en && fn_oe[slot];
                next_pu = pull_up_sw;
                next_pd = pull_dn_sw;
            end
        endcase
    end

    // Registered pad controls, high impedance during reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out       <= 1'b0;
            pad_oe        <= 1'b0;
            pad_pull_up   <= 1'b0;
            pad_pull_down <= 1'b0;
        end else begin
            pad_out       <= next_out;
            pad_oe        <= next_oe;
            pad_pull_up   <= next_pu;
            pad_pull_down <= next_pd;
        end
    end

    // Two-flop synchroniser, then route the level to the selected slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a    <= 1'b0;
            pad_level <= 1'b0;
            fn_in     <= 5'h00;
        end else begin
            sync_a    <= pad_in;
            pad_level <= sync_a;
            fn_in     <= (hit && dig_en) ? (5'(pad_level) << slot) : 5'h00;
        end
    end

    a_unlisted_hiz: assert property (@(posedge pclk) disable iff (!presetn)
        !hit |=> !pad_oe && fn_in == 5'h00)
        else $error("unlisted mode left the pad connected");
endmodule

// *** hw/pad_function_and_lowpower_state_control.sv ***
// Pad controller for the last two multiplexed pads, strap and antenna pads.
// Assumes an APB master on pclk and power-state levels from the same clock.
`timescale 1ns/10ps
`include "pad_ctrl_consts.svh"

// What this block does
// - Unused pads in deep sleep become inputs with weak pull-down.
// - Hibernate makes all digital pads except the strap pad high impedance with no pulls.
// - Boot strap / oscillator enable pad drives high from power-up.
// - In hibernate that pad floats with pull-down, stopping the oscillator.
// - Antenna-select pads are reserved for driving the antenna switch.
// - Boot firmware enables the digital path automatically during ROM boot.
// - Converter pass switch opens at reset; digital path stays disconnected until enabled.
module pad_function_and_lowpower_state_control (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        deep_sleep_state,
    input  wire logic        hibernate_state,
    input  wire logic        rom_boot_enable,
    input  wire logic [4:0]  pin63_fn_out,
    input  wire logic [4:0]  pin63_fn_oe,
    output logic      [4:0]  pin63_fn_in,
    input  wire logic [4:0]  pin64_fn_out,
    input  wire logic [4:0]  pin64_fn_oe,
    output logic      [4:0]  pin64_fn_in,
    input  wire logic        pin63_in,
    output logic             pin63_out,
    output logic             pin63_oe,
    output logic             pin63_pull_up,
    output logic             pin63_pull_down,
    input  wire logic        pin64_in,
    output logic             pin64_out,
    output logic             pin64_oe,
    output logic             pin64_pull_up,
    output logic             pin64_pull_down,
    output logic             boot_mode_strap_out,
    output logic             boot_mode_strap_oe,
    output logic             boot_mode_strap_pull_down,
    input  wire logic [1:0]  antenna_select,
    output logic      [1:0]  antenna_out,
    output logic      [1:0]  antenna_oe,
    output logic             flash_data_pull_down,
    output logic             flash_clk_pull_down,
    output logic             conv_pass_switch
);
    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [3:0]                    pin63_mode;
    logic [3:0]                    pin64_mode;
    logic [9:0]                    ctrl;
    logic                          dig_en;
    logic                          p63_level;
    logic                          p64_level;
    logic                          setup;
    logic                          access;
    logic                          wr_func63;
    logic                          wr_func64;
    logic                          wr_ctrl;
    logic                          mapped;
    logic [31:0]                   next_rdata;
    pad_ctrl_pkg::power_state_type power;

    assign setup     = psel && !penable;
    assign access    = psel && penable;
    assign wr_func63 = access && pwrite && paddr == `ADDR_PIN63_FUNC;
    assign wr_func64 = access && pwrite && paddr == `ADDR_PIN64_FUNC;
    assign wr_ctrl   = access && pwrite && paddr == `ADDR_PAD_CTRL;
    assign mapped    = paddr == `ADDR_PIN63_FUNC || paddr == `ADDR_PIN64_FUNC ||
                       paddr == `ADDR_PAD_CTRL || paddr == `ADDR_PAD_STATUS;

    // Zero-wait answer; unmapped addresses and status writes are errors
    assign pready  = 1'b1;
    assign pslverr = access && (!mapped || (pwrite && paddr == `ADDR_PAD_STATUS));

    // Hibernate outranks deep sleep
    always_comb begin
        if (hibernate_state) begin
            power = pad_ctrl_pkg::pwr_hibernate;
        end else if (deep_sleep_state) begin
            power = pad_ctrl_pkg::pwr_deep_sleep;
        end else begin
            power = pad_ctrl_pkg::pwr_active;
        end
    end

    // ****************************************************************
    // Function select and control registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin63_mode <= `MODE_RESET;
            pin64_mode <= `MODE_RESET;
        end else begin
            if (wr_func63) begin
                pin63_mode <= pwdata[`MODE_MSB:0];
            end
            if (wr_func64) begin
                pin64_mode <= pwdata[`MODE_MSB:0];
            end
        end
    end

    // Pulls, used marks and pass switch; switch opens at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 10'h000;
        end else if (wr_ctrl) begin
            ctrl <= pwdata[9:0];
        end
    end

    // Digital path: boot pulse sets it, a software clear loses to the set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dig_en <= 1'b0;
        end else if (rom_boot_enable) begin
            dig_en <= 1'b1;
        end else if (wr_ctrl) begin
            dig_en <= pwdata[`CTRL_DIG_EN];
        end
    end

    // Read data is captured in the setup phase
    always_comb begin
        case (paddr)
            `ADDR_PIN63_FUNC: next_rdata = {28'h0000000, pin63_mode};
            `ADDR_PIN64_FUNC: next_rdata = {28'h0000000, pin64_mode};
            `ADDR_PAD_CTRL:   next_rdata = {22'h0, dig_en, ctrl[8:0]};
            `ADDR_PAD_STATUS: next_rdata = {26'h0, p64_level, p63_level,
                                  conv_pass_switch && pin64_oe, dig_en,
                                  hibernate_state, deep_sleep_state};
            default:          next_rdata = `ZERO_WORD;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `ZERO_WORD;
        end else if (setup) begin
            prdata <= next_rdata;
        end
    end

    // ****************************************************************
    // Pad cells
    // ****************************************************************
    pad_mux_cell #(
        .MODE_S1 (`P63_CARD_IRQ),
        .MODE_S2 (`P63_FRAME_SYNC),
        .MODE_S3 (`P63_CAPTURE6),
        .MODE_S4 (`MODE_NONE),
        .SLOT_EN (`P63_SLOTS)
    ) u_pin63 (
        .pclk          (pclk),
        .presetn       (presetn),
        .mode          (pin63_mode),
        .power         (power),
        .dig_en        (dig_en),
        .used          (ctrl[`CTRL_P63_USED]),
        .pull_up_sw    (ctrl[`CTRL_P63_PU]),
        .pull_dn_sw    (ctrl[`CTRL_P63_PD]),
        .fn_out        (pin63_fn_out),
        .fn_oe         (pin63_fn_oe),
        .fn_in         (pin63_fn_in),
        .pad_in        (pin63_in),
        .pad_out       (pin63_out),
        .pad_oe        (pin63_oe),
        .pad_pull_up   (pin63_pull_up),
        .pad_pull_down (pin63_pull_down),
        .pad_level     (p63_level)
    );

    // Pad 64 is also the shared converter pad; closing the switch never cuts its digital path
    pad_mux_cell #(
        .MODE_S1 (`P64_PULSE5),
        .MODE_S2 (`P64_CARD_DATA0),
        .MODE_S3 (`P64_AUDIO_DATA0),
        .MODE_S4 (`P64_CAPTURE0),
        .SLOT_EN (`P64_SLOTS)
    ) u_pin64 (
        .pclk          (pclk),
        .presetn       (presetn),
        .mode          (pin64_mode),
        .power         (power),
        .dig_en        (dig_en),
        .used          (ctrl[`CTRL_P64_USED]),
        .pull_up_sw    (ctrl[`CTRL_P64_PU]),
        .pull_dn_sw    (ctrl[`CTRL_P64_PD]),
        .fn_out        (pin64_fn_out),
        .fn_oe         (pin64_fn_oe),
        .fn_in         (pin64_fn_in),
        .pad_in        (pin64_in),
        .pad_out       (pin64_out),
        .pad_oe        (pin64_oe),
        .pad_pull_up   (pin64_pull_up),
        .pad_pull_down (pin64_pull_down),
        .pad_level     (p64_level)
    );

    // ****************************************************************
    // Strap, antenna, flash pulls and pass switch
    // ****************************************************************
    // Strap pad is output only; floats with pull-down in hibernate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_mode_strap_out       <= 1'b1;
            boot_mode_strap_oe        <= 1'b1;
            boot_mode_strap_pull_down <= 1'b0;
        end else begin
            boot_mode_strap_out       <= !hibernate_state;
            boot_mode_strap_oe        <= !hibernate_state;
            boot_mode_strap_pull_down <= hibernate_state;
        end
    end

    // Antenna pads follow the radio's selection outside hibernate; they float low in hibernate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            antenna_out <= 2'h0;
            antenna_oe  <= 2'h0;
        end else begin
            antenna_out <= hibernate_state ? 2'h0 : antenna_select;
            antenna_oe  <= hibernate_state ? 2'h0 : 2'h3;
        end
    end

    // Flash pulls honoured outside hibernate; switch follows its bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_data_pull_down <= 1'b0;
            flash_clk_pull_down  <= 1'b0;
            conv_pass_switch     <= 1'b0;
        end else begin
            flash_data_pull_down <= ctrl[`CTRL_FLASH_PD] && !hibernate_state;
            flash_clk_pull_down  <= ctrl[`CTRL_FLASH_PD] && !hibernate_state;
            conv_pass_switch     <= ctrl[`CTRL_CONV_SW];
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_hib_pads_float: assert property (@(posedge pclk) disable iff (!presetn)
        hibernate_state |=> !pin63_oe && !pin64_oe && !pin63_pull_up && !pin64_pull_down
            && !pin63_pull_down && !pin64_pull_up && antenna_oe == 2'h0)
        else $error("pads not floating in hibernate");
    a_sleep_unused_pull: assert property (@(posedge pclk) disable iff (!presetn)
        deep_sleep_state && !hibernate_state && !ctrl[`CTRL_P63_USED]
            |=> pin63_pull_down && !pin63_oe && !pin63_pull_up)
        else $error("unused pad not pulled down in deep sleep");
    a_sleep_used_pull: assert property (@(posedge pclk) disable iff (!presetn)
        deep_sleep_state && !hibernate_state && ctrl[`CTRL_P64_USED]
            |=> pin64_pull_up == $past(ctrl[`CTRL_P64_PU]))
        else $error("software pull not honoured in deep sleep");
    a_strap_drive_high: assert property (@(posedge pclk) disable iff (!presetn)
        !hibernate_state [*2] |-> boot_mode_strap_oe && boot_mode_strap_out)
        else $error("strap pad not driven high");
    a_strap_hib_pull: assert property (@(posedge pclk) disable iff (!presetn)
        hibernate_state |=> !boot_mode_strap_oe && boot_mode_strap_pull_down)
        else $error("strap pad not floating with pull-down");
    a_boot_dig_path: assert property (@(posedge pclk) disable iff (!presetn)
        rom_boot_enable |=> dig_en)
        else $error("boot pulse lost");
    a_switch_by_write: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(conv_pass_switch) |-> $past(ctrl[`CTRL_CONV_SW]) && !$past(ctrl[`CTRL_CONV_SW], 2))
        else $error("pass switch closed without a write");
    a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_func63 |=> pin63_mode == $past(pwdata[`MODE_MSB:0])
            ##2 ($past(pin63_mode) != `MODE_GPIO || !$past(dig_en)
            || $past(hibernate_state) || $past(deep_sleep_state)
            || pin63_oe == $past(pin63_fn_oe[0])))
        else $error("mode write not applied");
    a_antenna_follow: assert property (@(posedge pclk) disable iff (!presetn)
        !hibernate_state |=> antenna_oe == 2'h3 && antenna_out == $past(antenna_select))
        else $error("antenna pads not following selection");
endmodule

// *** dv/pad_board_model.sv ***
// Board model for one package pad: pulls, external driver, floating line.
// Assumes the pad controls come from the design on the same clock.
`timescale 1ns/10ps

module pad_board_model (
    input  wire logic pclk,
    input  wire logic pad_out,
    input  wire logic pad_oe,
    input  wire logic pull_up,
    input  wire logic pull_down,
    input  wire logic ext_en,
    input  wire logic ext_level,
    output logic      pad_level
);
    logic flip;

    // Floating line shows a level that changes every cycle
    initial flip = 1'b0;
    always @(posedge pclk) flip <= ~flip;

    // Pad level from whoever drives or pulls the line
    always_comb begin
        if (pad_oe) begin
            pad_level = pad_out;
        end else if (ext_en) begin
            pad_level = ext_level;
        end else if (pull_up || pull_down) begin
            pad_level = pull_up;
        end else begin
            pad_level = flip;
        end
    end
endmodule

// *** dv/pad_function_and_lowpower_state_control_tb.sv ***
// Self-checking bench for the pad function and low-power state controller.
// Assumes the design files and the board model are compiled first.
`timescale 1ns/10ps
`include "pad_ctrl_consts.svh"
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %h got %h", nm, e, s); end end

module pad_function_and_lowpower_state_control_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_en, ext_lvl;
    logic [31:0] paddr, pwdata, prdata, seed;
    logic        deep_sleep_state, hibernate_state, rom_boot_enable, pin63_in, pin64_in;
    logic [4:0]  pin63_fn_out, pin63_fn_oe, pin63_fn_in, pin64_fn_out, pin64_fn_oe, pin64_fn_in;
    logic        pin63_out, pin63_oe, pin63_pull_up, pin63_pull_down, conv_pass_switch;
    logic        pin64_out, pin64_oe, pin64_pull_up, pin64_pull_down;
    logic        boot_mode_strap_out, boot_mode_strap_oe, boot_mode_strap_pull_down;
    logic        flash_data_pull_down, flash_clk_pull_down;
    logic [1:0]  antenna_select, antenna_out, antenna_oe;
    logic [32:0] exp_v;
    logic [32:0] exp_q[$];
    logic [3:0]  m63[4] = '{`MODE_GPIO, `P63_CARD_IRQ, `P63_FRAME_SYNC, `P63_CAPTURE6};
    logic [3:0]  m64[5] = '{`MODE_GPIO, `P64_PULSE5, `P64_CARD_DATA0, `P64_AUDIO_DATA0,
                            `P64_CAPTURE0};
    int          error_cnt = 0;
    int          n_checks = 0;

    pad_function_and_lowpower_state_control i_pad_function_and_lowpower_state_control (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .deep_sleep_state, .hibernate_state, .rom_boot_enable, .pin63_fn_out,
        .pin63_fn_oe, .pin63_fn_in, .pin64_fn_out, .pin64_fn_oe, .pin64_fn_in, .pin63_in,
        .pin63_out, .pin63_oe, .pin63_pull_up, .pin63_pull_down, .pin64_in, .pin64_out,
        .pin64_oe, .pin64_pull_up, .pin64_pull_down, .boot_mode_strap_out,
        .boot_mode_strap_oe, .boot_mode_strap_pull_down, .antenna_select, .antenna_out,
        .antenna_oe, .flash_data_pull_down, .flash_clk_pull_down, .conv_pass_switch);

    pad_board_model i_pad_board_model_63 (.pclk, .pad_out(pin63_out), .pad_oe(pin63_oe),
        .pull_up(pin63_pull_up), .pull_down(pin63_pull_down), .ext_en(ext_en),
        .ext_level(ext_lvl), .pad_level(pin63_in));
    pad_board_model i_pad_board_model_64 (.pclk, .pad_out(pin64_out), .pad_oe(pin64_oe),
        .pull_up(pin64_pull_up), .pull_down(pin64_pull_down), .ext_en(1'b0),
        .ext_level(1'b0), .pad_level(pin64_in));

    // Next value of the stimulus sequence
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // One APB transfer; the expected response goes to the queue
    task automatic apb(input logic w, input logic [31:0] a, d, input logic [32:0] e);
        exp_q.push_back(e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Let n edges pass, then sample away from the edge
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        #5;
    endtask

    // Print the counts and the verdict, then stop
    task automatic wrap_up;
        if (exp_q.size() != 0) error_cnt++;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Response watcher compares each completed transfer with the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            exp_v = exp_q.pop_front();
            if (pwrite) `CHK("apb error", exp_v[32], pslverr)
            else `CHK("apb read", exp_v, {pslverr, prdata})
        end
    end

    // Watchdog
    initial begin
        #(50 * 5000);
        error_cnt++;
        wrap_up();
    end

    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ext_en, ext_lvl} = '0;
        {deep_sleep_state, hibernate_state, rom_boot_enable, antenna_select} = '0;
        {pin63_fn_out, pin63_fn_oe, pin64_fn_out, pin64_fn_oe} = '0;
        seed = 32'hfa00;
        wt(3);
        `CHK("strap reset", 2'b11, {boot_mode_strap_out, boot_mode_strap_oe})
        `CHK("switch reset", 1'b0, conv_pass_switch)
        presetn <= 1'b1;
        apb(1'b0, `ADDR_PIN63_FUNC, 32'h0, 33'h0);
        apb(1'b0, 32'h4402e0d0, 32'h0, {1'b1, 32'h0});
        apb(1'b1, `ADDR_PAD_STATUS, 32'hffffffff, {1'b1, 32'h0});
        wt(0);
        `CHK("pads off", 2'b00, {pin63_oe, pin64_oe})
        @(posedge pclk);
        rom_boot_enable <= 1'b1;
        @(posedge pclk);
        rom_boot_enable <= 1'b0;
        apb(1'b0, `ADDR_PAD_CTRL, 32'h0, {1'b0, 32'h200});
        $display("test reset and boot done");
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            if (i < 4) apb(1'b1, `ADDR_PIN63_FUNC, {28'h0, m63[i]}, 33'h0);
            apb(1'b1, `ADDR_PIN64_FUNC, {28'h0, m64[i]}, 33'h0);
            apb(1'b0, `ADDR_PIN64_FUNC, 32'h0, {29'h0, m64[i]});
            pin63_fn_oe    <= 5'h1 << i;
            pin64_fn_oe    <= 5'h1 << i;
            pin63_fn_out   <= ~seed[4:0];
            pin64_fn_out   <= seed[4:0];
            antenna_select <= seed[6:5];
            wt(2);
            if (i < 4) `CHK("pin63 drive", {1'b1, ~seed[i]}, {pin63_oe, pin63_out})
            `CHK("pin64 drive", {1'b1, seed[i]}, {pin64_oe, pin64_out})
            `CHK("antenna", {2'b11, seed[6:5]}, {antenna_oe, antenna_out})
        end
        apb(1'b1, `ADDR_PIN64_FUNC, 32'h5, 33'h0);
        wt(2);
        `CHK("unlisted mode", 6'h0, {pin64_oe, pin64_fn_in})
        apb(1'b1, `ADDR_PIN63_FUNC, 32'h0, 33'h0);
        pin63_fn_oe <= 5'h0;
        ext_en      <= 1'b1;
        ext_lvl     <= seed[7];
        wt(4);
        `CHK("pin63 input", {4'h0, seed[7]}, pin63_fn_in)
        ext_en <= 1'b0;
        $display("test modes done");
        apb(1'b1, `ADDR_PIN64_FUNC, 32'h0, 33'h0);
        pin64_fn_oe <= 5'h1;
        apb(1'b1, `ADDR_PAD_CTRL, 32'h268, 33'h0);
        deep_sleep_state <= 1'b1;
        wt(4);
        `CHK("pin63 sleep", 3'b001, {pin63_oe, pin63_pull_up, pin63_pull_down})
        `CHK("pin64 sleep", 3'b110, {pin64_oe, pin64_pull_up, pin64_pull_down})
        `CHK("flash pulls", 2'b11, {flash_data_pull_down, flash_clk_pull_down})
        apb(1'b0, `ADDR_PAD_STATUS, 32'h0, {27'h0, seed[0], 5'b00101});
        hibernate_state <= 1'b1;
        wt(2);
        `CHK("pads hib", 4'h0, {pin63_oe, pin64_oe, pin63_pull_down, pin64_pull_up})
        `CHK("antenna hib", 2'b00, antenna_oe)
        `CHK("strap hib", 2'b01, {boot_mode_strap_oe, boot_mode_strap_pull_down})
        hibernate_state  <= 1'b0;
        deep_sleep_state <= 1'b0;
        wt(2);
        `CHK("strap wake", 2'b11, {boot_mode_strap_out, boot_mode_strap_oe})
        $display("test low power done");
        apb(1'b1, `ADDR_PIN64_FUNC, 32'hf, 33'h0);
        apb(1'b1, `ADDR_PAD_CTRL, 32'h300, 33'h0);
        wt(2);
        `CHK("switch closed", 2'b01, {pin64_oe, conv_pass_switch})
        presetn <= 1'b0;
        wt(1);
        `CHK("switch opened", 1'b0, conv_pass_switch)
        presetn <= 1'b1;
        apb(1'b0, `ADDR_PIN64_FUNC, 32'h0, 33'h0);
        $display("test converter switch done");
        wt(1);
        wrap_up();
    end
endmodule
